// File: test/ccgen_clock_ctrl_assertions.sv
// Concurrent checks on the clock generation control ports
`timescale 1ns/1ps
module ccgen_clock_ctrl_assertions (
    input wire logic mclk,
    input wire logic resetn,
    input wire ccgen_pkg::ccgen_bus_t busReq,
    input wire logic mainOscStop,
    input wire logic elcSwitchReq,
    input wire logic [ccgen_pkg::NCLK-1:0] clkTick,
    input wire logic accMeasClkEn,
    input wire logic [2:0] activeSrc,
    input wire logic elcStopEvent,
    input wire logic timerPinHiZ
);
    import ccgen_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    sequence s_stopEvt;
        ##[1:4] elcStopEvent;
    endsequence
    sequence s_toLoco;
        ##[0:6] activeSrc == SRC_LOW_SPEED_OSC;
    endsequence
    src_legal_a: assert property (activeSrc <= SRC_PLL)
        else $error("active source code out of range");
    stop_evt_a: assert property ($rose(mainOscStop) |-> s_stopEvt)
        else $error("no event after oscillator stop");
    evt_pulse_a: assert property (elcStopEvent |=> !elcStopEvent)
        else $error("stop event longer than one cycle");
    stop_hiz_a: assert property (elcStopEvent |-> timerPinHiZ)
        else $error("timer pins not released on stop");
    stop_low_speed_osc_a: assert property (elcStopEvent |-> s_toLoco)
        else $error("no fall back to low speed source");
    elc_low_speed_osc_a: assert property (elcSwitchReq |-> s_toLoco)
        else $error("link event did not select low speed source");
    gate_quiet_a: assert property ($changed(activeSrc) |-> $past(clkTick) == '0)
        else $error("ticks seen during source change");
    acc_clk_a: assert property (clkTick[0] |-> accMeasClkEn)
        else $error("accuracy clock not running");
    hiz_hold_a: assert property (timerPinHiZ && !busReq.wr |=> timerPinHiZ)
        else $error("pin release without software clear");
endmodule

// File: test/ccgen_osc_model.sv
// Oscillator side model: main oscillator stop and sub-clock settling
`timescale 1ns/1ps
module ccgen_osc_model #(
    parameter int SUB_WAIT = 40
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic killMain,
    output wire logic mainOscStop,
    output logic subOscReady
);
    int waitCnt;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            waitCnt <= 0;
            subOscReady <= 1'b0;
        end else begin
            if (waitCnt < SUB_WAIT) waitCnt <= waitCnt + 1;
            subOscReady <= (waitCnt >= SUB_WAIT);
        end
    end
    // Stop arrives off the clock edge
    assign #7 mainOscStop = killMain;
endmodule

// File: test/tb_clock_generation_control.sv
// Self-checking bench for the clock generation control block
`timescale 1ns/1ps
module tb_clock_generation_control;
    import ccgen_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    ccgen_bus_t busReq = '0;
    logic killMain = 1'b0;
    logic elcSwitchReq = 1'b0;
    logic mainOscStop, subOscReady, accMeasClkEn, fllEnable, busClkPin, elcStopEvent, timerPinHiZ;
    logic [DATA_W-1:0] rdata, rv;
    logic [NCLK-1:0] clkTick;
    logic [2:0] activeSrc;
    logic [1:0] hocoFreqSel;
    ccgen_pll_t pllCfg;
    int errorCnt = 0;
    int checkCount = 0;
    int tc [NCLK];
    int pinCnt;

    always #25 mclk = ~mclk;

    ccgen_clock_ctrl i_dut (.mclk, .resetn, .busReq, .rdata, .mainOscStop, .subOscReady, .elcSwitchReq,
        .clkTick, .accMeasClkEn, .activeSrc, .pllCfg, .hocoFreqSel, .fllEnable, .busClkPin,
        .elcStopEvent, .timerPinHiZ);
    ccgen_osc_model i_osc (.mclk, .resetn, .killMain, .mainOscStop, .subOscReady);

    task automatic testDone();
        $display("errors=%0d checks=%0d", errorCnt, checkCount);
        if (errorCnt == 0 && checkCount > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic timeout();
        errorCnt++;
        testDone();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        busReq.addr <= a;
        busReq.wdata <= d;
        busReq.wr <= 1'b1;
        @(posedge mclk);
        busReq.wr <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        busReq.addr <= a;
        busReq.rd <= 1'b1;
        @(posedge mclk);
        busReq.rd <= 1'b0;
        @(negedge mclk);
        rv = rdata;
    endtask
    task automatic waitSrc(input logic [2:0] s);
        int i;
        for (i = 0; i < 40 && activeSrc !== s; i++) @(negedge mclk);
        if (i == 40) timeout();
    endtask
    task automatic countTicks(input int n);
        logic lastPin;
        tc = '{default: 0};
        pinCnt = 0;
        @(negedge mclk);
        lastPin = busClkPin;
        repeat (n) begin
            @(negedge mclk);
            for (int k = 0; k < NCLK; k++) tc[k] += clkTick[k];
            pinCnt += (busClkPin != lastPin);
            lastPin = busClkPin;
        end
    endtask

    task automatic scResetVals();
        rd(OFS_SRC);
        check(rv, 32'h0000_0010);
        check(accMeasClkEn, 1'b1);
        check(pllCfg, 8'h0a);
        rd(OFS_STAT);
        check(rv[1], 1'b0);
        rd(8'h40);
        check(rv, 32'h0000_0000);
    endtask
    task automatic scTimerDiv();
        logic [3:0] code [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6};
        int ratio [6] = '{1, 2, 4, 8, 32, 64};
        foreach (code[i]) begin
            wr(OFS_SRC, {24'h0, code[i], 4'h0});
            repeat (70) @(posedge mclk);
            countTicks(128);
            check(tc[CLK_TIMER], 128 / ratio[i]);
        end
        wr(OFS_SRC, 32'h0000_0040);
        rd(OFS_SRC);
        check(rv, 32'h0000_0060);
    endtask
    task automatic scDividers();
        wr(OFS_DIV, 32'h0005_0301);
        wr(OFS_AUX, 32'h0000_0310);
        repeat (70) @(posedge mclk);
        countTicks(64);
        check(tc[0], 32);
        check(tc[1], 64);
        check(tc[2], 8);
        check(tc[4], 2);
        check(tc[3], 64);
        check(tc[CLK_BUS], 64);
        check(tc[CLK_FD], 16);
        check(tc[CLK_USB], 0);
        check(fllEnable, 1'b0);
        check(pinCnt, 64);
        wr(OFS_AUX, 32'h0000_0030);
        countTicks(64);
        check(pinCnt, 32);
        wr(OFS_AUX, 32'h0000_0000);
        countTicks(64);
        check(pinCnt, 0);
        check(busClkPin, 1'b1);
    endtask
    task automatic scPllHoco();
        wr(OFS_PLL, 32'h0000_1e05);
        check(pllCfg, 8'hde);
        wr(OFS_PLL, 32'h0000_0901);
        check(pllCfg, 8'h9e);
        wr(OFS_PLL, 32'h0000_0a06);
        check(pllCfg, 8'h0a);
        for (int h = 0; h < 4; h++) begin
            wr(OFS_AUX, 32'h0001_0000 | h);
            check(hocoFreqSel, h == 3 ? 2 : h);
            check(fllEnable, 1'b1);
        end
    endtask
    task automatic scSource();
        logic [2:0] codes [5] = '{SRC_MAIN, SRC_HIGH_SPEED_OSC, SRC_SUB, SRC_PLL, SRC_LOW_SPEED_OSC};
        rd(OFS_STAT);
        check(rv[1], 1'b1);
        foreach (codes[i]) begin
            wr(OFS_SRC, {21'h0, codes[i], 8'h10});
            waitSrc(codes[i]);
            check(activeSrc, codes[i]);
        end
        wr(OFS_SRC, 32'h0000_0510);
        repeat (6) @(posedge mclk);
        check(activeSrc, SRC_LOW_SPEED_OSC);
    endtask
    task automatic scStop();
        int i;
        wr(OFS_SRC, 32'h0000_0210);
        waitSrc(SRC_MAIN);
        @(posedge mclk);
        killMain <= 1'b1;
        for (i = 0; i < 20 && elcStopEvent !== 1'b1; i++) @(negedge mclk);
        if (i == 20) timeout();
        check(timerPinHiZ, 1'b1);
        waitSrc(SRC_LOW_SPEED_OSC);
        rd(OFS_STAT);
        check(rv[6:0], 7'h43);
        @(posedge mclk);
        killMain <= 1'b0;
        wr(OFS_STAT, 32'h0000_0001);
        rd(OFS_STAT);
        check(rv[6:0], 7'h02);
    endtask
    task automatic scElc();
        wr(OFS_SRC, 32'h0000_0410);
        waitSrc(SRC_PLL);
        @(posedge mclk);
        elcSwitchReq <= 1'b1;
        @(posedge mclk);
        elcSwitchReq <= 1'b0;
        waitSrc(SRC_LOW_SPEED_OSC);
        rd(OFS_SRC);
        check(rv[10:8], SRC_LOW_SPEED_OSC);
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        scResetVals();
        scTimerDiv();
        scDividers();
        scPllHoco();
        scSource();
        scStop();
        scElc();
        testDone();
    end
endmodule

bind ccgen_clock_ctrl ccgen_clock_ctrl_assertions i_chk (.mclk, .resetn, .busReq, .mainOscStop,
    .elcSwitchReq, .clkTick, .accMeasClkEn, .activeSrc, .elcStopEvent, .timerPinHiZ);

// File: verilog/ccgen_clock_ctrl.sv
// Clock generation control: source select, PLL setup, dividers, stop detection
`timescale 1ns/1ps

module ccgen_clock_ctrl #(
    parameter bit HAS_SUB = 1'b1,
    parameter bit HAS_TIMER = 1'b1,
    parameter bit HAS_FD = 1'b1,
    parameter bit HAS_USB = 1'b0
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire ccgen_pkg::ccgen_bus_t busReq,
    output logic [ccgen_pkg::DATA_W-1:0] rdata,
    input wire logic mainOscStop,
    input wire logic subOscReady,
    input wire logic elcSwitchReq,
    output logic [ccgen_pkg::NCLK-1:0] clkTick,
    output logic accMeasClkEn,
    output logic [2:0] activeSrc,
    output ccgen_pkg::ccgen_pll_t pllCfg,
    output logic [1:0] hocoFreqSel,
    output logic fllEnable,
    output logic busClkPin,
    output logic elcStopEvent,
    output logic timerPinHiZ
);
    import ccgen_pkg::*;

    typedef struct packed {
        logic [2:0] src;
        logic [2:0] pend;
        ccgen_state_t st;
        logic [GATE_W-1:0] gateCnt;
        logic [DIVF_W-1:0] tdiv;
        logic [NDIVREG-1:0][DIVF_W-1:0] divs;
        ccgen_pll_t pll;
        logic [1:0] high_speed_osc;
        logic bpEn;
        logic bpDiv2;
        logic [DIVF_W-1:0] fdDiv;
        logic [DIVF_W-1:0] usbDiv;
        logic fll;
        logic stopS1;
        logic stopS2;
        logic stopS3;
        logic subS1;
        logic subS2;
        logic stopFlag;
        logic hiZ;
        logic evt;
        logic [NCLK-1:0][CNT_W-1:0] cnt;
        logic [NCLK-1:0][CNT_W-1:0] term;
        logic [NCLK-1:0] tick;
        logic busLvl;
        logic busHalf;
        logic pin;
        logic meas;
        logic [DATA_W-1:0] rdata;
    } ccgen_st_t;

    ccgen_st_t r_r;
    ccgen_st_t r_nxt;
    logic [NCLK-1:0][CNT_W-1:0] wantTerm;
    logic [NCLK-1:0] present;
    logic [DATA_W-1:0] wd;
    logic stopRise;

    // Shift-coded divider: 1, 2, 4, 8, 32, 64
    function automatic logic [CNT_W-1:0] shiftTerm(input logic [DIVF_W-1:0] code);
        logic [CNT_W:0] ratio;
        ratio = (CNT_W + 1)'(1) << code[2:0];
        return CNT_W'(ratio - (CNT_W + 1)'(1));
    endfunction

    // Gap code and codes above the top ratio are refused
    function automatic logic divLegal(input logic [DIVF_W-1:0] code);
        logic ok;
        ok = 1'b0;
        if (code <= DIV_MAX) begin
            ok = (code != DIV_HOLE);
        end
        return ok;
    endfunction

    // Sub-clock code only where the oscillator exists
    function automatic logic srcLegal(input logic [2:0] code);
        logic ok;
        unique case (code)
            SRC_LOW_SPEED_OSC, SRC_HIGH_SPEED_OSC, SRC_MAIN, SRC_PLL: begin
                ok = 1'b1;
            end
            SRC_SUB: begin
                ok = HAS_SUB;
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction

    assign wd = busReq.wdata;
    assign stopRise = r_r.stopS2 && !r_r.stopS3;

    // Ratios to load at the next wrap of each divider
    always_comb begin
        for (int k = 0; k < NDIVREG; k++) begin
            wantTerm[k] = shiftTerm(r_r.divs[k]);
        end
        wantTerm[CLK_TIMER] = shiftTerm(r_r.tdiv);
        // CAN-FD divide by code plus one
        wantTerm[CLK_FD] = CNT_W'(r_r.fdDiv);
        // USB divide by code plus one
        wantTerm[CLK_USB] = CNT_W'(r_r.usbDiv);
    end

    // Clocks that this variant carries
    always_comb begin
        present = '1;
        present[CLK_TIMER] = HAS_TIMER;
        present[CLK_FD] = HAS_FD;
        present[CLK_USB] = HAS_USB;
    end

    always_comb begin
        r_nxt = r_r;
        r_nxt.tick = '0;
        r_nxt.evt = 1'b0;
        r_nxt.rdata = '0;
        r_nxt.stopS1 = mainOscStop;
        r_nxt.stopS2 = r_r.stopS1;
        r_nxt.stopS3 = r_r.stopS2;
        r_nxt.subS1 = subOscReady;
        r_nxt.subS2 = r_r.subS1;
        // undivided clock to the accuracy circuit
        r_nxt.meas = 1'b1;

        if (busReq.wr) begin
            unique case (busReq.addr)
                OFS_SRC: begin
                    if (srcLegal(wd[SRC_MSB:SRC_LSB])) begin
                        r_nxt.pend = wd[SRC_MSB:SRC_LSB];
                    end
                    // field kept at its reset code without timer
                    if (HAS_TIMER && divLegal(wd[TDIV_MSB:TDIV_LSB])) begin
                        r_nxt.tdiv = wd[TDIV_MSB:TDIV_LSB];
                    end
                end
                OFS_DIV: begin
                    for (int k = 0; k < NDIVREG; k++) begin
                        if (divLegal(wd[k*DIVF_W +: DIVF_W])) begin
                            r_nxt.divs[k] = wd[k*DIVF_W +: DIVF_W];
                        end
                    end
                end
                OFS_PLL: begin
                    r_nxt.pll.refHoco = wd[PLL_REF_BIT];
                    // input divide 1, 2 or 3
                    if (wd[INDIV_MSB:INDIV_LSB] <= INDIV_MAX) begin
                        r_nxt.pll.inDiv = wd[INDIV_MSB:INDIV_LSB];
                    end
                    if (wd[MULT_MSB:MULT_LSB] >= MULT_MIN && wd[MULT_MSB:MULT_LSB] <= MULT_MAX) begin
                        r_nxt.pll.mult = wd[MULT_MSB:MULT_LSB];
                    end
                end
                OFS_AUX: begin
                    if (wd[HIGH_SPEED_OSC_MSB:HIGH_SPEED_OSC_LSB] <= HIGH_SPEED_OSC_MAX) begin
                        r_nxt.high_speed_osc = wd[HIGH_SPEED_OSC_MSB:HIGH_SPEED_OSC_LSB];
                    end
                    r_nxt.bpEn = wd[BPEN_BIT];
                    r_nxt.bpDiv2 = wd[BPDIV2_BIT];
                    if (HAS_FD) begin
                        r_nxt.fdDiv = wd[FD_MSB:FD_LSB];
                    end
                    if (HAS_USB) begin
                        r_nxt.usbDiv = wd[USB_MSB:USB_LSB];
                    end
                    r_nxt.fll = HAS_SUB && wd[FLL_BIT];
                end
                OFS_STAT: begin
                    if (wd[STAT_STOP_BIT]) begin
                        r_nxt.stopFlag = 1'b0;
                        r_nxt.hiZ = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // stop forces low osc and pin release; set beats clear
        if (stopRise) begin
            r_nxt.stopFlag = 1'b1;
            r_nxt.hiZ = 1'b1;
            r_nxt.pend = SRC_LOW_SPEED_OSC;
            r_nxt.evt = 1'b1;
        end
        if (elcSwitchReq) begin
            r_nxt.pend = SRC_LOW_SPEED_OSC;
        end

        unique case (r_r.st)
            CG_RUN: begin
                if (r_nxt.pend != r_r.src) begin
                    // quiet all divided clock ticks before changing source; accuracy clock enable stays on
                    r_nxt.st = CG_GATE;
                    r_nxt.gateCnt = GATE_W'(GATE_CYC - 1);
                end else begin
                    for (int k = 0; k < NCLK; k++) begin
                        if (present[k]) begin
                            // new ratio only at a wrap
                            if (r_r.cnt[k] == r_r.term[k]) begin
                                r_nxt.tick[k] = 1'b1;
                                r_nxt.cnt[k] = '0;
                                r_nxt.term[k] = wantTerm[k];
                            end else begin
                                r_nxt.cnt[k] = r_r.cnt[k] + CNT_W'(1);
                            end
                        end
                    end
                end
            end
            CG_GATE: begin
                if (r_r.gateCnt == '0) begin
                    r_nxt.src = r_nxt.pend;
                    r_nxt.st = CG_RUN;
                    r_nxt.cnt = '0;
                    r_nxt.term = wantTerm;
                end else begin
                    r_nxt.gateCnt = r_r.gateCnt - GATE_W'(1);
                end
            end
        endcase

        // Bus clock level flips on each bus tick; half rate on its rise
        if (r_nxt.tick[CLK_BUS]) begin
            r_nxt.busLvl = !r_r.busLvl;
            if (!r_r.busLvl) begin
                r_nxt.busHalf = !r_r.busHalf;
            end
        end
        // steady high when clock output is off
        if (!r_nxt.bpEn) begin
            r_nxt.pin = 1'b1;
        end else if (r_nxt.bpDiv2) begin
            r_nxt.pin = r_nxt.busHalf;
        end else begin
            r_nxt.pin = r_nxt.busLvl;
        end

        if (busReq.rd) begin
            unique case (busReq.addr)
                OFS_SRC: begin
                    r_nxt.rdata[SRC_MSB:SRC_LSB] = r_r.pend;
                    r_nxt.rdata[TDIV_MSB:TDIV_LSB] = r_r.tdiv;
                end
                OFS_DIV: begin
                    r_nxt.rdata[NDIVREG*DIVF_W-1:0] = r_r.divs;
                end
                OFS_PLL: begin
                    r_nxt.rdata[PLL_REF_BIT] = r_r.pll.refHoco;
                    r_nxt.rdata[INDIV_MSB:INDIV_LSB] = r_r.pll.inDiv;
                    r_nxt.rdata[MULT_MSB:MULT_LSB] = r_r.pll.mult;
                end
                OFS_AUX: begin
                    r_nxt.rdata[HIGH_SPEED_OSC_MSB:HIGH_SPEED_OSC_LSB] = r_r.high_speed_osc;
                    r_nxt.rdata[BPEN_BIT] = r_r.bpEn;
                    r_nxt.rdata[BPDIV2_BIT] = r_r.bpDiv2;
                    r_nxt.rdata[FD_MSB:FD_LSB] = r_r.fdDiv;
                    r_nxt.rdata[USB_MSB:USB_LSB] = r_r.usbDiv;
                    r_nxt.rdata[FLL_BIT] = r_r.fll;
                end
                OFS_STAT: begin
                    r_nxt.rdata[STAT_STOP_BIT] = r_r.stopFlag;
                    r_nxt.rdata[STAT_SUBOK_BIT] = HAS_SUB && r_r.subS2;
                    r_nxt.rdata[STAT_SRC_MSB:STAT_SRC_LSB] = r_r.src;
                    r_nxt.rdata[STAT_SWITCH_BIT] = (r_r.st == CG_GATE);
                    r_nxt.rdata[STAT_HIZ_BIT] = r_r.hiZ;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            r_r <= '0;
            r_r.src <= SRC_LOW_SPEED_OSC;
            r_r.pend <= SRC_LOW_SPEED_OSC;
            r_r.st <= CG_RUN;
            r_r.tdiv <= TDIV_RST;
            r_r.pll.mult <= MULT_MIN;
            r_r.pin <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign rdata = r_r.rdata;
    assign clkTick = r_r.tick;
    assign accMeasClkEn = r_r.meas;
    assign activeSrc = r_r.src;
    assign pllCfg = r_r.pll;
    assign hocoFreqSel = r_r.high_speed_osc;
    assign fllEnable = r_r.fll;
    assign busClkPin = r_r.pin;
    assign elcStopEvent = r_r.evt;
    assign timerPinHiZ = r_r.hiZ;
endmodule

// File: verilog/ccgen_pkg.sv
// Constants and types of the clock generation control block
package ccgen_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_SRC = 8'h00;
    localparam logic [7:0] OFS_DIV = 8'h04;
    localparam logic [7:0] OFS_PLL = 8'h08;
    localparam logic [7:0] OFS_AUX = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;

    // Source register fields
    localparam int SRC_LSB = 8;
    localparam int SRC_MSB = 10;
    localparam int TDIV_LSB = 4;
    localparam int TDIV_MSB = 7;
    // PLL register fields
    localparam int PLL_REF_BIT = 0;
    localparam int INDIV_LSB = 1;
    localparam int INDIV_MSB = 2;
    localparam int MULT_LSB = 8;
    localparam int MULT_MSB = 12;
    // Auxiliary register fields
    localparam int HIGH_SPEED_OSC_LSB = 0;
    localparam int HIGH_SPEED_OSC_MSB = 1;
    localparam int BPEN_BIT = 4;
    localparam int BPDIV2_BIT = 5;
    localparam int FD_LSB = 8;
    localparam int FD_MSB = 11;
    localparam int USB_LSB = 12;
    localparam int USB_MSB = 15;
    localparam int FLL_BIT = 16;
    // Status register fields
    localparam int STAT_STOP_BIT = 0;
    localparam int STAT_SUBOK_BIT = 1;
    localparam int STAT_SRC_LSB = 2;
    localparam int STAT_SRC_MSB = 4;
    localparam int STAT_SWITCH_BIT = 5;
    localparam int STAT_HIZ_BIT = 6;

    // System clock source codes
    localparam logic [2:0] SRC_LOW_SPEED_OSC = 3'h0;
    localparam logic [2:0] SRC_HIGH_SPEED_OSC = 3'h1;
    localparam logic [2:0] SRC_MAIN = 3'h2;
    localparam logic [2:0] SRC_SUB = 3'h3;
    localparam logic [2:0] SRC_PLL = 3'h4;

    // Divider codes and limits
    localparam int DIVF_W = 4;
    localparam int CNT_W = 6;
    localparam logic [3:0] TDIV_RST = 4'h1;
    localparam logic [3:0] DIV_HOLE = 4'h4;
    localparam logic [3:0] DIV_MAX = 4'h6;
    localparam logic [1:0] INDIV_MAX = 2'h2;
    localparam logic [4:0] MULT_MIN = 5'h0a;
    localparam logic [4:0] MULT_MAX = 5'h1e;
    localparam logic [1:0] HIGH_SPEED_OSC_MAX = 2'h2;

    // Derived clock indices; the first NDIVREG sit in the divider register
    localparam int NCLK = 9;
    localparam int NDIVREG = 6;
    localparam int CLK_BUS = 5;
    localparam int CLK_TIMER = 6;
    localparam int CLK_FD = 7;
    localparam int CLK_USB = 8;

    // Quiet time while the source changes over
    localparam int CLK_PERIOD_NS = 50;
    localparam int GATE_TIME_NS = 100;
    localparam int GATE_CYC = (GATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GATE_W = 2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } ccgen_bus_t;

    typedef struct packed {
        logic refHoco;
        logic [1:0] inDiv;
        logic [4:0] mult;
    } ccgen_pll_t;

    typedef enum logic {CG_RUN, CG_GATE} ccgen_state_t;
endpackage
